/* design/gpf_pkg.sv */
package gpf_pkg;
	localparam int NUM_PINS = 12;
	localparam int NUM_SRC  = 4;
	localparam int SEL_W    = 2;
	localparam int MODE_W   = 3;
	localparam int FLT_W    = 4;

	// Drive modes
	typedef enum logic [2:0] {
		DM_INPUT_ONLY = 3'h0,
		DM_WEAK_UP_STRONG_DN = 3'h1,
		DM_STRONG_UP_WEAK_DN = 3'h2,
		DM_OD_STRONG_DN = 3'h3,
		DM_OD_STRONG_UP = 3'h4,
		DM_STRONG_BOTH = 3'h5,
		DM_WEAK_BOTH = 3'h6
	} gpf_mode_type;

	// Fault mapping modes
	typedef enum logic [1:0] {
		FM_OFF = 2'h0,
		FM_SPLIT = 2'h1,
		FM_OR_A = 2'h2,
		FM_OR_B = 2'h3
	} gpf_fmap_type;

	// Fault bit positions
	localparam int FLT_OCP = 0;
	localparam int FLT_SCP = 1;
	localparam int FLT_OVP = 2;
	localparam int FLT_UVP = 3;

	localparam int PIN_FLT_A = 0;
	localparam int PIN_FLT_B = 1;

	localparam logic [2:0]  RST_MODE  = 3'h0;
	localparam logic [11:0] RST_PINS  = 12'h000;
endpackage

/* design/gpf_hold_cell.sv */
`timescale 1ns/1ps
// One pin's hold latch, clocked by the always-on low-frequency clock
module gpf_hold_cell (
	input  wire logic       i_lf_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_hold,
	input  wire logic       i_out,
	input  wire logic       i_oe,
	input  wire logic [2:0] i_mode,
	output logic            o_out,
	output logic            o_oe,
	output logic [2:0]      o_mode
);
	logic       out_ff;
	logic       oe_ff;
	logic [2:0] mode_ff;
	logic       nxt_out;
	logic       nxt_oe;
	logic [2:0] nxt_mode;

	// Track live values until hold freezes them
	always_comb begin
		nxt_out  = i_hold ? out_ff : i_out;
		nxt_oe   = i_hold ? oe_ff : i_oe;
		nxt_mode = i_hold ? mode_ff : i_mode;
	end

	// Runs off the slow clock so deep sleep keeps the state
	always_ff @(posedge i_lf_clk) begin
		if (i_sys_rst) begin
			out_ff  <= 1'b0;
			oe_ff   <= 1'b0;
			mode_ff <= gpf_pkg::RST_MODE;
		end else begin
			out_ff  <= nxt_out;
			oe_ff   <= nxt_oe;
			mode_ff <= nxt_mode;
		end
	end

	// Released: live values pass straight through
	assign o_out  = i_hold ? out_ff : i_out;
	assign o_oe   = i_hold ? oe_ff : i_oe;
	assign o_mode = i_hold ? mode_ff : i_mode;
endmodule

/* design/gpf_pad_ctl.sv */
`timescale 1ns/1ps
// Translates drive mode plus output value into pad up/down drive controls
module gpf_pad_ctl (
	input  wire logic       i_en,
	input  wire logic       i_out,
	input  wire logic       i_oe,
	input  wire logic [2:0] i_mode,
	output logic            o_up_strong,
	output logic            o_up_weak,
	output logic            o_dn_strong,
	output logic            o_dn_weak,
	output logic            o_drive
);
	logic hi;
	logic lo;

	// Disabled pin drives nothing at all
	always_comb begin
		hi = i_en & i_oe & i_out;
		lo = i_en & i_oe & ~i_out;
		o_up_strong = 1'b0;
		o_up_weak   = 1'b0;
		o_dn_strong = 1'b0;
		o_dn_weak   = 1'b0;
		unique case (gpf_pkg::gpf_mode_type'(i_mode))
			gpf_pkg::DM_WEAK_UP_STRONG_DN: begin
				o_up_weak   = hi;
				o_dn_strong = lo;
			end
			gpf_pkg::DM_STRONG_UP_WEAK_DN: begin
				o_up_strong = hi;
				o_dn_weak   = lo;
			end
			gpf_pkg::DM_OD_STRONG_DN: begin
				o_dn_strong = lo;
			end
			gpf_pkg::DM_OD_STRONG_UP: begin
				o_up_strong = hi;
			end
			gpf_pkg::DM_STRONG_BOTH: begin
				o_up_strong = hi;
				o_dn_strong = lo;
			end
			gpf_pkg::DM_WEAK_BOTH: begin
				o_up_weak = hi;
				o_dn_weak = lo;
			end
			default: begin
			end
		endcase
		o_drive = o_up_strong | o_up_weak | o_dn_strong | o_dn_weak;
	end
endmodule

/* design/gpf_port.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Twelve general pins, some lendable to serial blocks via routing.
// - Seven drive modes per pin, input only through weak both ways.
// - Per-pin input threshold select, CMOS or LVTTL.
// - Input and output buffers enabled separately, beyond drive mode.
// - Per-pin hold latches the previous state through deep sleep.
// - Per-pin selectable output slew rate to limit noise.
// - During power-on or reset every pin is disabled, no input or output.
// - A routing matrix picks which internal signal drives each pin.
// - First two port-one pins can indicate OCP, SCP, OVP, UVP faults.
// - Two faults one per pin, or all four ORed onto one pin.
// - In deep sleep only the slow clock runs the pin hold logic.
module gpf_port (
	input  wire logic        i_sys_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	input  wire logic        i_lf_clk,
	input  wire logic        i_por_active,
	input  wire logic        i_deep_sleep,
	input  wire logic [11:0] i_gpio_out,
	input  wire logic [11:0] i_gpio_oe,
	input  wire logic [11:0] i_periph_out,
	input  wire logic [11:0] i_periph_oe,
	input  wire logic [11:0] i_scb_out,
	input  wire logic [11:0] i_scb_oe,
	input  wire logic [23:0] i_route_sel,
	input  wire logic [35:0] i_drive_mode,
	input  wire logic [11:0] i_thresh_lvttl,
	input  wire logic [11:0] i_slow_slew,
	input  wire logic [11:0] i_in_buf_en,
	input  wire logic [11:0] i_out_buf_en,
	input  wire logic [11:0] i_hold,
	input  wire logic [3:0]  i_fault,
	input  wire logic [1:0]  i_fault_map,
	input  wire logic [1:0]  i_fault_sel_a,
	input  wire logic [1:0]  i_fault_sel_b,
	input  wire logic [11:0] i_pad_in,
	output logic      [11:0] o_pad_out,
	output logic      [11:0] o_pad_oe,
	output logic      [11:0] o_up_strong,
	output logic      [11:0] o_up_weak,
	output logic      [11:0] o_dn_strong,
	output logic      [11:0] o_dn_weak,
	output logic      [11:0] o_thresh_lvttl,
	output logic      [11:0] o_slow_slew,
	output logic      [11:0] o_in_buf_en,
	output logic      [11:0] o_pin_in
);
	localparam int N = gpf_pkg::NUM_PINS;

	logic [N-1:0] route_out;
	logic [N-1:0] route_oe;
	logic [N-1:0] hold_out;
	logic [N-1:0] hold_oe;
	logic [N-1:0] up_s;
	logic [N-1:0] up_w;
	logic [N-1:0] dn_s;
	logic [N-1:0] dn_w;
	logic [N-1:0] drv;
	logic [N-1:0] pin_en;
	logic         fault_a;
	logic         fault_b;
	logic         fault_any;

	logic [N-1:0] pin_in_ff;
	logic [N-1:0] nxt_pin_in;
	logic [N-1:0] thr_ff;
	logic [N-1:0] nxt_thr;
	logic [N-1:0] slew_ff;
	logic [N-1:0] nxt_slew;
	logic [N-1:0] inen_ff;
	logic [N-1:0] nxt_inen;
	logic [3*N-1:0] mode_live;
	logic [N-1:0]   hold_req;
	logic         rst_seen_ff;
	logic         nxt_rst_seen;

	// Fault indicator selection
	always_comb begin
		fault_any = |i_fault;
		fault_a   = 1'b0;
		fault_b   = 1'b0;
		unique case (gpf_pkg::gpf_fmap_type'(i_fault_map))
			gpf_pkg::FM_OFF: begin
			end
			gpf_pkg::FM_SPLIT: begin
				unique case (i_fault_sel_a)
					2'h0: fault_a = i_fault[gpf_pkg::FLT_OCP];
					2'h1: fault_a = i_fault[gpf_pkg::FLT_SCP];
					2'h2: fault_a = i_fault[gpf_pkg::FLT_OVP];
					2'h3: fault_a = i_fault[gpf_pkg::FLT_UVP];
				endcase
				unique case (i_fault_sel_b)
					2'h0: fault_b = i_fault[gpf_pkg::FLT_OCP];
					2'h1: fault_b = i_fault[gpf_pkg::FLT_SCP];
					2'h2: fault_b = i_fault[gpf_pkg::FLT_OVP];
					2'h3: fault_b = i_fault[gpf_pkg::FLT_UVP];
				endcase
			end
			gpf_pkg::FM_OR_A: begin
				fault_a = fault_any;
			end
			gpf_pkg::FM_OR_B: begin
				fault_b = fault_any;
			end
		endcase
	end

	// Routing matrix: 0 gpio, 1 peripheral, 2 serial block, 3 fault on the two indicator pins, off on the rest
	always_comb begin
		for (int p = 0; p < N; p++) begin
			unique case (i_route_sel[2*p +: 2])
				2'h0: begin
					route_out[p] = i_gpio_out[p];
					route_oe[p]  = i_gpio_oe[p];
				end
				2'h1: begin
					route_out[p] = i_periph_out[p];
					route_oe[p]  = i_periph_oe[p];
				end
				2'h2: begin
					route_out[p] = i_scb_out[p];
					route_oe[p]  = i_scb_oe[p];
				end
				default: begin
					route_out[p] = 1'b0;
					route_oe[p]  = 1'b0;
				end
			endcase
		end
		// Only the two indicator pins can carry faults
		if (i_route_sel[2*gpf_pkg::PIN_FLT_A +: 2] == 2'h3) begin
			route_out[gpf_pkg::PIN_FLT_A] = fault_a;
			route_oe[gpf_pkg::PIN_FLT_A]  = 1'b1;
		end
		if (i_route_sel[2*gpf_pkg::PIN_FLT_B +: 2] == 2'h3) begin
			route_out[gpf_pkg::PIN_FLT_B] = fault_b;
			route_oe[gpf_pkg::PIN_FLT_B]  = 1'b1;
		end
	end

	// Output buffer enable gates the routed enable before hold
	logic [N-1:0] live_oe;
	always_comb begin
		live_oe = route_oe & i_out_buf_en;
	end

	// Pins are disabled during reset or power-on
	always_comb begin
		pin_en = {N{~(i_sys_rst | i_por_active)}};
	end

	// Unused mode code falls back to input only, so a stray value never drives
	always_comb begin
		for (int p = 0; p < N; p++) begin
			if (i_drive_mode[3*p +: 3] == 3'h7) begin
				mode_live[3*p +: 3] = gpf_pkg::DM_INPUT_ONLY;
			end else begin
				mode_live[3*p +: 3] = i_drive_mode[3*p +: 3];
			end
		end
	end

	// Deep sleep holds every pin on top of its own hold bit
	always_comb begin
		hold_req = i_hold | {N{i_deep_sleep}};
	end

	// Per-pin hold and pad decode
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			logic [2:0] mode_h;
			gpf_hold_cell u_hold (
				.i_lf_clk  (i_lf_clk),
				.i_sys_rst (i_sys_rst),
				.i_hold    (hold_req[g]),
				.i_out     (route_out[g]),
				.i_oe      (live_oe[g]),
				.i_mode    (mode_live[3*g +: 3]),
				.o_out     (hold_out[g]),
				.o_oe      (hold_oe[g]),
				.o_mode    (mode_h)
			);
			gpf_pad_ctl u_pad (
				.i_en        (pin_en[g]),
				.i_out       (hold_out[g]),
				.i_oe        (hold_oe[g]),
				.i_mode      (mode_h),
				.o_up_strong (up_s[g]),
				.o_up_weak   (up_w[g]),
				.o_dn_strong (dn_s[g]),
				.o_dn_weak   (dn_w[g]),
				.o_drive     (drv[g])
			);
		end
	endgenerate

	// Pad drive is combinational so held state survives a stopped main clock
	assign o_up_strong = up_s;
	assign o_up_weak   = up_w;
	assign o_dn_strong = dn_s;
	assign o_dn_weak   = dn_w;
	assign o_pad_oe    = drv & pin_en;
	assign o_pad_out   = hold_out & pin_en;

	// Marks that reset is over; the input path waits on it
	always_comb begin
		nxt_rst_seen = 1'b1;
	end

	// Reset-seen flag
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rst_seen_ff <= 1'b0;
		end else if (i_clk_en) begin
			rst_seen_ff <= nxt_rst_seen;
		end
	end

	// Input threshold select follows its control
	always_comb begin
		nxt_thr = i_thresh_lvttl;
	end

	// Threshold register
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			thr_ff <= gpf_pkg::RST_PINS;
		end else if (i_clk_en) begin
			thr_ff <= nxt_thr;
		end
	end

	// Slew select follows its control
	always_comb begin
		nxt_slew = i_slow_slew;
	end

	// Slew register
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			slew_ff <= gpf_pkg::RST_PINS;
		end else if (i_clk_en) begin
			slew_ff <= nxt_slew;
		end
	end

	// Input buffer enable follows its control
	always_comb begin
		nxt_inen = i_in_buf_en;
	end

	// Input buffer enable register; reset forces inputs off
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			inen_ff <= gpf_pkg::RST_PINS;
		end else if (i_clk_en) begin
			inen_ff <= nxt_inen;
		end
	end

	// Sampled pad level; a disabled input buffer reads low
	always_comb begin
		nxt_pin_in = i_pad_in & i_in_buf_en;
	end

	// Pin input register
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			pin_in_ff <= gpf_pkg::RST_PINS;
		end else if (i_clk_en) begin
			pin_in_ff <= nxt_pin_in;
		end
	end

	// Input path stays off until reset and power-on are both over
	assign o_in_buf_en    = inen_ff & {N{rst_seen_ff & ~i_por_active}};
	assign o_pin_in       = pin_in_ff & {N{~i_por_active}};
	assign o_thresh_lvttl = thr_ff;
	assign o_slow_slew    = slew_ff;
endmodule

/* dv/gpf_port_monitor.sv */
`timescale 1ns/1ps
module gpf_port_monitor (
	input wire logic        i_sys_clk,
	input wire logic        i_sys_rst,
	input wire logic        i_clk_en,
	input wire logic        i_por_active,
	input wire logic        i_deep_sleep,
	input wire logic [35:0] i_drive_mode,
	input wire logic [23:0] i_route_sel,
	input wire logic [11:0] i_slow_slew,
	input wire logic [11:0] i_out_buf_en,
	input wire logic [11:0] i_hold,
	input wire logic [3:0]  i_fault,
	input wire logic [1:0]  i_fault_map,
	input wire logic [11:0] o_pad_out,
	input wire logic [11:0] o_pad_oe,
	input wire logic [11:0] o_slow_slew,
	input wire logic [11:0] o_in_buf_en,
	input wire logic [11:0] o_pin_in
);
	// Pad path transparent unless sleeping or powering up
	wire live = !i_deep_sleep && !i_por_active;
	wire held = i_hold[5] || i_deep_sleep;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	property p_por; i_por_active |-> o_pad_oe == 12'h000; endproperty
	a_por: assert property (p_por) else $error("pad on in por");
	property p_rst; $fell(i_sys_rst) |-> o_in_buf_en == 12'h000 && o_pin_in == 12'h000; endproperty
	a_rst: assert property (p_rst) else $error("input side live in reset");
	property p_slew; i_clk_en |=> o_slow_slew == $past(i_slow_slew); endproperty
	a_slew: assert property (p_slew) else $error("slew not taken");
	property p_frz; !i_clk_en |=> $stable(o_slow_slew); endproperty
	a_frz: assert property (p_frz) else $error("slew moved while gated");
	property p_inonly; live && !i_hold[0] && (i_drive_mode[2:0] == 3'h0 || !i_out_buf_en[0])
		|-> !o_pad_oe[0]; endproperty
	a_inonly: assert property (p_inonly) else $error("pin 0 driven");
	property p_rt3; live && !i_hold[2] && i_route_sel[5:4] == 2'h3 |-> !o_pad_oe[2]; endproperty
	a_rt3: assert property (p_rt3) else $error("pin 2 driven on fault route");
	property p_or; live && !i_hold[1] && i_route_sel[3:2] == 2'h3 && i_fault_map == 2'h3
		&& $stable(i_fault) && $stable(i_fault_map) && o_pad_oe[1]
		|-> o_pad_out[1] == |i_fault; endproperty
	a_or: assert property (p_or) else $error("fault or wrong");
	property p_hold; held && $past(held) && !i_por_active && !$past(i_por_active)
		&& !$past(i_sys_rst) |-> $stable(o_pad_out[5]) && $stable(o_pad_oe[5]); endproperty
	a_hold: assert property (p_hold) else $error("held pin moved");
endmodule
bind gpf_port gpf_port_monitor mon (.*);

/* dv/gpf_board.sv */
`timescale 1ns/1ps
// Board side: driven pins read back, released pins float unless pulled
module gpf_board (
	input  wire logic        i_sys_clk,
	input  wire logic [11:0] i_pad_out,
	input  wire logic [11:0] i_pad_oe,
	input  wire logic [11:0] i_up_weak,
	output logic      [11:0] o_pad_in
);
	logic [11:0] float_ff = 12'h5a5;
	// Floating level wanders so a stale value never reads as valid
	always_ff @(posedge i_sys_clk) begin
		float_ff <= ~float_ff;
	end
	assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & (i_up_weak | float_ff));
endmodule

/* dv/test_gpio_port_with_fault_flags.sv */
`timescale 1ns/1ps
module test_gpio_port_with_fault_flags;
	logic        i_sys_clk, i_sys_rst, i_clk_en, i_lf_clk, i_por_active, i_deep_sleep;
	logic [11:0] i_gpio_out, i_gpio_oe, i_periph_out, i_periph_oe, i_scb_out, i_scb_oe;
	logic [11:0] i_thresh_lvttl, i_slow_slew, i_in_buf_en, i_out_buf_en, i_hold, i_pad_in;
	logic [23:0] i_route_sel;
	logic [35:0] i_drive_mode;
	logic [3:0]  i_fault;
	logic [1:0]  i_fault_map, i_fault_sel_a, i_fault_sel_b;
	logic [11:0] o_pad_out, o_pad_oe, o_up_strong, o_up_weak, o_dn_strong, o_dn_weak;
	logic [11:0] o_thresh_lvttl, o_slow_slew, o_in_buf_en, o_pin_in;
	int          fails, n_tests;
	gpf_port uut (.*);
	gpf_board board (.i_sys_clk(i_sys_clk), .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
		.i_up_weak(o_up_weak), .o_pad_in(i_pad_in));
	// Slow clock out of phase with the system clock
	initial begin
		i_sys_clk = 0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		i_lf_clk = 0;
		#3;
		forever #10 i_lf_clk = ~i_lf_clk;
	end
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic t_por();
		@(negedge i_sys_clk);
		i_por_active = 1;
		#1;
		chk("por_oe", 12'h000, o_pad_oe);
		@(negedge i_sys_clk);
		chk("por_ibe", 12'h000, o_in_buf_en | o_pin_in);
		i_por_active = 0;
	endtask
	// Every leg of every mode, both output levels
	task automatic t_modes();
		logic up, dn, uw, dw;
		for (int m = 0; m < 8; m++) begin
			for (int v = 0; v < 2; v++) begin
				@(negedge i_sys_clk);
				i_drive_mode = {12{m[2:0]}};
				i_gpio_out = {12{v[0]}};
				#1;
				up = v[0] && (m == 2 || m == 4 || m == 5);
				dn = !v[0] && (m == 1 || m == 3 || m == 5);
				chk("up_strong", {12{up}}, o_up_strong);
				chk("dn_strong", {12{dn}}, o_dn_strong);
				uw = v[0] && (m == 1 || m == 6);
				dw = !v[0] && (m == 2 || m == 6);
				chk("up_weak", {12{uw}}, o_up_weak);
				chk("dn_weak", {12{dw}}, o_dn_weak);
			end
		end
		@(negedge i_sys_clk);
		i_drive_mode = {12{3'h5}};
		i_out_buf_en = 12'h000;
		#1;
		chk("obe_off", 12'h000, o_pad_oe);
		i_out_buf_en = 12'hfff;
	endtask
	task automatic t_route();
		i_gpio_out = 12'h3c5;
		for (int r = 0; r < 4; r++) begin
			@(negedge i_sys_clk);
			i_route_sel = {12{r[1:0]}};
			#1;
			if (r < 3) begin
				chk("route", r == 0 ? i_gpio_out : r == 1 ? i_periph_out : i_scb_out, o_pad_out);
			end else begin
				chk("route_off", 12'h000, o_pad_oe & 12'hffc);
			end
		end
	endtask
	task automatic t_cfg();
		@(negedge i_sys_clk);
		i_route_sel = 24'h00_0000;
		i_thresh_lvttl = 12'ha5a;
		i_slow_slew = 12'h3c3;
		i_in_buf_en = 12'h0f0;
		repeat (2) @(negedge i_sys_clk);
		chk("lvttl", 12'ha5a, o_thresh_lvttl);
		chk("slew", 12'h3c3, o_slow_slew);
		chk("pin_in", i_gpio_out & 12'h0f0, o_pin_in);
		chk("in_buf_en", 12'h0f0, o_in_buf_en);
		i_clk_en = 0;
		i_thresh_lvttl = 12'hfff;
		@(negedge i_sys_clk);
		chk("lvttl_frz", 12'ha5a, o_thresh_lvttl);
		i_clk_en = 1;
		i_in_buf_en = 12'hfff;
	endtask
	// Every fault pattern through split and both or pins
	task automatic t_fault();
		logic [1:0] e;
		i_route_sel = 24'h00_000f;
		for (int k = 1; k < 4; k++) begin
			for (int f = 0; f < 16; f++) begin
				@(negedge i_sys_clk);
				i_fault_map = k[1:0];
				i_fault = f[3:0];
				i_fault_sel_a = f[1:0];
				i_fault_sel_b = ~f[1:0];
				repeat (2) @(negedge i_sys_clk);
				e = k == 1 ? {i_fault[i_fault_sel_b], i_fault[i_fault_sel_a]} : {2{|i_fault}};
				chk("fault", {10'h000, e & (k == 1 ? 2'h3 : k == 2 ? 2'h1 : 2'h2)},
					o_pad_out & {10'h000, k == 1 ? 2'h3 : k == 2 ? 2'h1 : 2'h2});
			end
		end
		i_route_sel = 24'h00_0000;
	endtask
	task automatic t_hold();
		for (int k = 0; k < 2; k++) begin
			@(negedge i_sys_clk);
			i_gpio_out = 12'hfff;
			@(posedge i_lf_clk);
			@(negedge i_sys_clk);
			i_hold = k == 0 ? 12'hfff : 12'h000;
			i_deep_sleep = k[0];
			repeat (3) @(posedge i_lf_clk);
			@(negedge i_sys_clk);
			i_gpio_out = 12'h000;
			i_drive_mode = 36'h0_0000_0000;
			#1;
			chk("held_out", 12'hfff, o_pad_out & o_up_strong);
			i_hold = 12'h000;
			i_deep_sleep = 0;
			#1;
			chk("released", 12'h000, o_pad_oe);
			i_drive_mode = {12{3'h5}};
		end
	endtask
	initial begin
		{i_por_active, i_deep_sleep, i_fault, i_fault_map, i_fault_sel_a, i_fault_sel_b} = 0;
		{i_gpio_out, i_thresh_lvttl, i_slow_slew, i_hold, i_route_sel} = 0;
		{i_gpio_oe, i_periph_oe, i_scb_oe, i_in_buf_en, i_out_buf_en} = {60{1'b1}};
		i_periph_out = 12'h0f0;
		i_scb_out = 12'hf0f;
		i_drive_mode = {12{3'h5}};
		i_clk_en = 1;
		i_sys_rst = 1;
		repeat (3) @(negedge i_sys_clk);
		chk("rst_oe", 12'h000, o_pad_oe | o_in_buf_en);
		@(negedge i_sys_clk);
		i_sys_rst = 0;
		t_por();
		t_modes();
		t_route();
		t_cfg();
		t_fault();
		t_hold();
		final_report();
	end
	// Run needs about two hundred cycles
	initial begin
		#200000;
		fails++;
		final_report();
	end
endmodule
